// File: design/peepc_host.sv
/*
 * host controller for a parallel 8k x 8 eeprom with page writes,
 * data polling and software write protection commands.
 * assumes the eeprom pins are wired directly; data lines are a split
 * input/output/enable triple resolved outside this module.
 */
//
// Overview of operation
// - write only with select, strobe low, gate high
// - next byte loaded within 200 us
// - protected device needs unlock prefix per page
// - enable is aa/1555, 55/0aaa, a0/1555
// - enable must be followed by page data
// - disable is six writes ending 20/1555
// - clear is six writes ending 10/1555
`timescale 1ns/1ps
module peepc_host (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// user request port
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic [2:0] i_req_op,
	input wire logic [12:0] i_req_addr,
	input wire logic [7:0] i_req_data,
	input wire logic i_req_last,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	output logic o_busy,
	// eeprom pins
	output logic [12:0] o_addr,
	output logic o_sel_n,
	output logic o_gate_n,
	output logic o_wstb_n,
	input wire logic [7:0] i_data_lines,
	output logic [7:0] o_data_lines,
	output logic o_data_lines_oe
);

	// ********************************************************
	// state and registers
	// ********************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WSETUP = 3'b001,
		ST_WLOW = 3'b010,
		ST_WHOLD = 3'b011,
		ST_RLOW = 3'b100,
		ST_POLL = 3'b101,
		ST_PGAP = 3'b110
	} peepc_state_e;

	peepc_state_e state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [2:0] step_q, step_d;
	logic [2:0] nsteps_q, nsteps_d;
	logic [2:0] op_q, op_d;
	logic [12:0] addr_q, addr_d;
	logic [7:0] wdat_q, wdat_d;
	logic [7:0] last_q, last_d;
	logic [12:0] last_addr_q, last_addr_d;
	logic last_byte_q, last_byte_d;
	logic poll_q, poll_d;
	logic [7:0] rsp_q, rsp_d;
	logic rsp_v_q, rsp_v_d;
	logic wstb_n_q, wstb_n_d;
	logic [7:0] din_s1_q, din_s2_q;

	// ********************************************************
	// command prefix lookup
	// ********************************************************
	function automatic logic [20:0] peepc_prefix(input logic [2:0] s,
			input logic [2:0] op);
		logic [7:0] fin;
		fin = (op == 3'(peepc_pkg::PEEPC_OP_UNPROT)) ?
			peepc_pkg::CMD_DAT_UNPROT : peepc_pkg::CMD_DAT_CLEAR;
		case (s)
			3'h0, 3'h3: peepc_prefix = {peepc_pkg::CMD_ADDR_A,
				peepc_pkg::CMD_DAT_AA};
			3'h1, 3'h4: peepc_prefix = {peepc_pkg::CMD_ADDR_B,
				peepc_pkg::CMD_DAT_55};
			3'h2: peepc_prefix = {peepc_pkg::CMD_ADDR_A,
				(op == 3'(peepc_pkg::PEEPC_OP_PROT)) ?
				peepc_pkg::CMD_DAT_PROT : peepc_pkg::CMD_DAT_EXT};
			default: peepc_prefix = {peepc_pkg::CMD_ADDR_A, fin};
		endcase
	endfunction : peepc_prefix

	// ********************************************************
	// decode of the incoming request
	// ********************************************************
	wire logic take = i_req_valid && o_req_ready;
	wire logic is_read = i_req_op == 3'(peepc_pkg::PEEPC_OP_READ);
	wire logic is_prot = i_req_op == 3'(peepc_pkg::PEEPC_OP_PROT);
	wire logic is_write = i_req_op == 3'(peepc_pkg::PEEPC_OP_WRITE);
	wire logic is_cmd6 = i_req_op == 3'(peepc_pkg::PEEPC_OP_UNPROT) ||
		i_req_op == 3'(peepc_pkg::PEEPC_OP_CLEAR);
	wire logic in_prefix = step_q < nsteps_q;
	wire logic [20:0] pfx = peepc_prefix(step_q, op_q);
	wire logic strobe_done = cnt_q == 16'(peepc_pkg::STROBE_CYC - 1);
	wire logic setup_done = cnt_q == 16'(peepc_pkg::SETUP_CYC - 1);
	wire logic read_done = cnt_q == 16'(peepc_pkg::READ_CYC - 1);
	// stay well inside the byte-load window between loads
	wire logic gap_ok = cnt_q < 16'(peepc_pkg::LOAD_GAP_CYC / 2);
	// polling: complement means still programming
	wire logic poll_busy = din_s2_q != last_q;

	// ********************************************************
	// data line synchroniser
	// ********************************************************
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			din_s1_q <= 8'h00;
			din_s2_q <= 8'h00;
		end else begin
			din_s1_q <= i_data_lines;
			din_s2_q <= din_s1_q;
		end
	end

	// ********************************************************
	// sequencer
	// ********************************************************
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h0001;
		step_d = step_q;
		nsteps_d = nsteps_q;
		op_d = op_q;
		addr_d = addr_q;
		wdat_d = wdat_q;
		last_d = last_q;
		last_addr_d = last_addr_q;
		last_byte_d = last_byte_q;
		poll_d = poll_q;
		rsp_d = rsp_q;
		rsp_v_d = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (take) begin
					op_d = i_req_op;
					addr_d = i_req_addr;
					wdat_d = i_req_data;
					last_byte_d = i_req_last || is_cmd6;
					cnt_d = 16'h0000;
					step_d = 3'h0;
					if (is_read) begin
						state_d = ST_RLOW;
					end else begin
						// prefix of 0, 3 or 6 command writes
						nsteps_d = is_prot ? 3'h3 : (is_cmd6 ? 3'h6 : 3'h0);
						state_d = ST_WSETUP;
					end
				end else if (poll_q && !gap_ok) begin
					// load window lapses; device now programs
					cnt_d = 16'h0000;
					state_d = ST_POLL;
				end
			end
			ST_WSETUP: begin
				if (setup_done) begin
					cnt_d = 16'h0000;
					state_d = ST_WLOW;
				end
			end
			ST_WLOW: begin
				// pulse well over 10 ns so it is accepted
				if (strobe_done) begin
					cnt_d = 16'h0000;
					state_d = ST_WHOLD;
				end
			end
			ST_WHOLD: begin
				if (setup_done) begin
					cnt_d = 16'h0000;
					if (in_prefix) begin
						step_d = step_q + 3'h1;
						if (step_q + 3'h1 == nsteps_q &&
								op_q == 3'(peepc_pkg::PEEPC_OP_CLEAR)) begin
							// clear: poll on all-ones result
							last_d = 8'hff;
							last_addr_d = peepc_pkg::CMD_ADDR_A;
							poll_d = 1'b1;
							state_d = ST_POLL;
						end else begin
							state_d = ST_WSETUP;
						end
					end else begin
						last_d = wdat_q;
						last_addr_d = addr_q;
						poll_d = 1'b1;
						// data follows prefix in the same page
						state_d = last_byte_q ? ST_POLL : ST_IDLE;
					end
				end
			end
			ST_RLOW: begin
				if (read_done) begin
					rsp_d = din_s2_q;
					rsp_v_d = 1'b1;
					cnt_d = 16'h0000;
					state_d = ST_IDLE;
				end
			end
			ST_POLL: begin
				if (read_done) begin
					cnt_d = 16'h0000;
					state_d = poll_busy ? ST_PGAP : ST_IDLE;
					poll_d = poll_busy;
				end
			end
			ST_PGAP: begin
				if (setup_done) begin
					cnt_d = 16'h0000;
					state_d = ST_POLL;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		wstb_n_d = state_d != ST_WLOW; // flop keeps strobe glitch free
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			cnt_q <= 16'h0000;
			step_q <= 3'h0;
			nsteps_q <= 3'h0;
			op_q <= 3'h0;
			addr_q <= 13'h0000;
			wdat_q <= 8'h00;
			last_q <= 8'h00;
			last_addr_q <= 13'h0000;
			last_byte_q <= 1'b0;
			poll_q <= 1'b0;
			rsp_q <= 8'h00;
			rsp_v_q <= 1'b0;
			wstb_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			step_q <= step_d;
			nsteps_q <= nsteps_d;
			op_q <= op_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			last_q <= last_d;
			last_addr_q <= last_addr_d;
			last_byte_q <= last_byte_d;
			poll_q <= poll_d;
			rsp_q <= rsp_d;
			rsp_v_q <= rsp_v_d;
			wstb_n_q <= wstb_n_d;
		end
	end

	// ********************************************************
	// pin drive
	// ********************************************************
	wire logic wr_phase = state_q == ST_WSETUP || state_q == ST_WLOW ||
		state_q == ST_WHOLD;
	wire logic rd_phase = state_q == ST_RLOW || state_q == ST_POLL;
	// select low 7 cycles before strobe falls, gate held high to write
	assign o_wstb_n = wstb_n_q;
	assign o_sel_n = !(wr_phase || rd_phase);
	assign o_gate_n = !rd_phase;
	// address steady across the whole strobe for edge capture
	assign o_addr = (state_q == ST_POLL) ? last_addr_q :
		(wr_phase && in_prefix) ? pfx[20:8] : addr_q;
	assign o_data_lines = (wr_phase && in_prefix) ? pfx[7:0] : wdat_q;
	assign o_data_lines_oe = wr_phase;
	// idle takes any op; an open page takes only its next byte load
	assign o_req_ready = state_q == ST_IDLE &&
		(!poll_q || (gap_ok && is_write));
	assign o_busy = poll_q || state_q != ST_IDLE;
	assign o_rsp_valid = rsp_v_q;
	assign o_rsp_data = rsp_q;

endmodule : peepc_host

// File: shared/peepc_pkg.sv
/*
 * constants for the host-side controller of a parallel 8k x 8 eeprom:
 * pin widths, command addresses and data, strobe and polling timing.
 * assumes a 125 mhz system clock driving the controller.
 */
package peepc_pkg;

	// ********************************************************
	// pin widths and page size
	// ********************************************************
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int PAGE_BYTES = 64;

	// ********************************************************
	// command sequence addresses and data
	// ********************************************************
	localparam logic [12:0] CMD_ADDR_A = 13'h1555;
	localparam logic [12:0] CMD_ADDR_B = 13'h0aaa;
	localparam logic [7:0] CMD_DAT_AA = 8'haa;
	localparam logic [7:0] CMD_DAT_55 = 8'h55;
	localparam logic [7:0] CMD_DAT_PROT = 8'ha0;
	localparam logic [7:0] CMD_DAT_EXT = 8'h80;
	localparam logic [7:0] CMD_DAT_UNPROT = 8'h20;
	localparam logic [7:0] CMD_DAT_CLEAR = 8'h10;

	// ********************************************************
	// timing
	// ********************************************************
	localparam int CLK_PERIOD_PS = 8000;
	localparam int STROBE_LOW_NS = 150;
	localparam int SETUP_NS = 50;
	localparam int READ_ACC_NS = 120;
	localparam int BYTE_LOAD_MAX_US = 200;
	localparam int STROBE_CYC = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int READ_CYC = (READ_ACC_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	// longest gap between loads, rounded down
	localparam int LOAD_GAP_CYC = (BYTE_LOAD_MAX_US * 1000000)
		/ CLK_PERIOD_PS;
	localparam int CNT_W = 16;

	// ********************************************************
	// request operations
	// ********************************************************
	typedef enum logic [2:0] {
		PEEPC_OP_READ = 3'b000,
		PEEPC_OP_WRITE = 3'b001,
		PEEPC_OP_PROT = 3'b010,
		PEEPC_OP_UNPROT = 3'b011,
		PEEPC_OP_CLEAR = 3'b100
	} peepc_op_e;

endpackage : peepc_pkg

// File: test/peepc_eeprom_model.sv
/* behavioural eeprom behind peepc_host, times in ns
 * the bench resolves the shared data lines */
`timescale 1ns/1ps
module peepc_eeprom_model #(
	parameter int WIN_NS = 10000,
	parameter int PROG_NS = 5000
) (
	input wire logic [12:0] i_addr,
	input wire logic i_sel_n,
	input wire logic i_gate_n,
	input wire logic i_wstb_n,
	input wire logic [7:0] i_data_lines,
	output logic [7:0] o_data_lines,
	output logic o_data_lines_oe
);
	localparam logic [41:0] HEAD = {13'h1555, 8'haa, 13'h0aaa, 8'h55};
	logic [7:0] mem [8192];
	logic [20:0] kq [$];
	logic [20:0] lk = 21'h000000;
	logic [12:0] a;
	logic ok = 0;
	logic busy = 0;
	logic prot = 0;
	int n = 0;
	wire wr = !i_sel_n && !i_wstb_n && i_gate_n;
	// ********
	// read path
	// ********
	assign o_data_lines_oe = !i_sel_n && !i_gate_n;
	assign o_data_lines = busy && i_addr == lk[20:8] ? ~lk[7:0]
		: mem[i_addr];
	initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h3c;
	// ********
	// byte load and page program
	// ********
	always @(posedge wr) begin
		a = i_addr;
		ok = 0;
		#10 ok = wr;
	end
	always @(negedge wr) if (ok) begin
		lk = {a, i_data_lines};
		kq.push_back(lk);
		busy = 1;
		n++;
		fork
			begin
				automatic int k = n;
				#(WIN_NS) if (k == n) close_page();
			end
		join_none
	end
	task automatic close_page();
		int s;
		logic w;
		s = 0;
		if (kq.size() > 2 && {kq[0], kq[1]} == HEAD) begin
			if (kq[2] == {13'h1555, 8'ha0})
				s = 3;
			else if (kq.size() > 5 && {kq[2], kq[3], kq[4]} ==
				{13'h1555, 8'h80, HEAD}) begin
				if (kq[5] == {13'h1555, 8'h20})
					s = 6;
				if (kq[5] == {13'h1555, 8'h10})
					s = 9;
			end
		end
		w = !prot || s != 0;
		if (s == 3)
			prot = 1;
		if (s == 6 && kq.size() > 6)
			prot = 0;
		#(s == 9 ? 4 * PROG_NS : PROG_NS);
		for (int i = s; i < kq.size(); i++)
			if (w)
				mem[{kq[s][20:14], kq[i][13:8]}] = kq[i][7:0];
		if (s == 9)
			foreach (mem[i]) mem[i] = 8'hff;
		kq.delete();
		busy = 0;
	endtask : close_page
endmodule : peepc_eeprom_model

// File: test/peepc_host_assertions.sv
/* pin checker bound onto peepc_host
 * sees only the host's own ports, one clock domain */
`timescale 1ns/1ps
module peepc_chk (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic o_req_ready,
	input wire logic o_busy,
	input wire logic [12:0] o_addr,
	input wire logic o_sel_n,
	input wire logic o_gate_n,
	input wire logic o_wstb_n,
	input wire logic [7:0] o_data_lines,
	input wire logic o_data_lines_oe
);
	// ********
	// pin timing
	// ********
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_rd; !o_gate_n |-> o_wstb_n && !o_data_lines_oe; endproperty
	a_rd: assert property (p_rd)
		else $error("write during read");
	property p_wr;
		!o_wstb_n |-> !o_sel_n && o_gate_n && o_data_lines_oe;
	endproperty
	a_wr: assert property (p_wr)
		else $error("bad write combination");
	property p_hold;
		!o_wstb_n |-> $stable(o_addr) && $stable(o_data_lines);
	endproperty
	a_hold: assert property (p_hold)
		else $error("address or data moved in strobe");
	property p_rise;
		$rose(o_wstb_n) |-> !o_sel_n && o_data_lines_oe && $stable(o_data_lines);
	endproperty
	a_rise: assert property (p_rise)
		else $error("data released at strobe rise");
	property p_wid;
		$fell(o_wstb_n) |-> (!o_wstb_n)[*8] ##10 !o_wstb_n;
	endproperty
	a_wid: assert property (p_wid)
		else $error("strobe too short");
	property p_setup; $fell(o_wstb_n) |-> $past(o_sel_n, 6) == 1'b0; endproperty
	a_setup: assert property (p_setup)
		else $error("select not set up before strobe");
	property p_poll;
		$fell(o_gate_n) |-> (!o_gate_n)[*8] ##1 (!o_gate_n)[*7] ##1 o_gate_n;
	endproperty
	a_poll: assert property (p_poll)
		else $error("read access length wrong");
	property p_busy; !o_sel_n |-> o_busy && !o_req_ready; endproperty
	a_busy: assert property (p_busy)
		else $error("ready while pins active");
endmodule : peepc_chk
bind peepc_host peepc_chk u_peepc_chk (.i_clk_sys, .i_rst, .o_req_ready,
	.o_busy, .o_addr, .o_sel_n, .o_gate_n, .o_wstb_n, .o_data_lines,
	.o_data_lines_oe);

// File: test/peepc_host_tb.sv
/* self-checking bench: peepc_host driving the eeprom model
 * needs the model and the bound checker compiled alongside */
`timescale 1ns/1ps
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("Error %0t: got %h want %h", $time, g, e); \
	end \
end
module peepc_host_tb;
	logic clk = 0;
	logic rst = 1;
	logic v = 0;
	logic l = 0;
	logic [2:0] op = 3'h0;
	logic [12:0] ra = 13'h0000;
	logic [7:0] rd = 8'h00;
	logic rdy, rv, busy, sel_n, gate_n, wstb_n, h_oe, m_oe;
	logic [7:0] rsp, h_d, m_d;
	logic [12:0] pa;
	wire [7:0] dl = h_oe ? h_d : m_oe ? m_d : ~m_d;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	peepc_host u_peepc_host (.i_clk_sys(clk), .i_rst(rst), .i_req_valid(v),
		.o_req_ready(rdy), .i_req_op(op), .i_req_addr(ra), .i_req_data(rd),
		.i_req_last(l), .o_rsp_valid(rv), .o_rsp_data(rsp), .o_busy(busy),
		.o_addr(pa), .o_sel_n(sel_n), .o_gate_n(gate_n), .o_wstb_n(wstb_n),
		.i_data_lines(dl), .o_data_lines(h_d), .o_data_lines_oe(h_oe));
	peepc_eeprom_model u_peepc_eeprom_model (.i_addr(pa), .i_sel_n(sel_n),
		.i_gate_n(gate_n), .i_wstb_n(wstb_n), .i_data_lines(dl),
		.o_data_lines(m_d), .o_data_lines_oe(m_oe));
	// ********
	// clock, hang guard, bus tasks
	// ********
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic req(input logic [2:0] o, input logic [12:0] a,
		input logic [7:0] d, input logic last);
		@(negedge clk);
		v = 1;
		op = o;
		ra = a;
		rd = d;
		l = last;
		do @(posedge clk); while (rdy !== 1'b1);
		@(negedge clk);
		v = 0;
	endtask : req
	task automatic idle();
		while (busy !== 1'b0) @(negedge clk);
	endtask : idle
	task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
		req(3'h0, a, 8'h00, 1'b0);
		while (rv !== 1'b1) @(negedge clk);
		`CHK(rsp, e)
	endtask : rdchk
	// ********
	// scenarios
	// ********
	task automatic t_page();
		rdchk(13'h1fff, 8'hc3);
		req(3'h1, 13'h0105, 8'h11, 1'b0);
		req(3'h1, 13'h0101, 8'h22, 1'b0);
		req(3'h1, 13'h0105, 8'h33, 1'b1);
		while (gate_n !== 1'b0) @(negedge clk);
		`CHK(dl, 8'hcc)
		idle();
		rdchk(13'h0105, 8'h33);
		rdchk(13'h0101, 8'h22);
		rdchk(13'h0102, 8'h3e);
		$display("page test done");
	endtask : t_page
	task automatic t_prot();
		req(3'h2, 13'h0200, 8'h44, 1'b1);
		idle();
		rdchk(13'h0200, 8'h44);
		req(3'h1, 13'h0201, 8'hee, 1'b0);
		req(3'h1, 13'h0202, 8'h3e, 1'b1);
		idle();
		rdchk(13'h0201, 8'h3d);
		req(3'h3, 13'h0203, 8'h55, 1'b1);
		idle();
		rdchk(13'h0203, 8'h55);
		req(3'h1, 13'h0204, 8'h66, 1'b1);
		idle();
		rdchk(13'h0204, 8'h66);
		$display("protect test done");
	endtask : t_prot
	task automatic t_gap();
		req(3'h1, 13'h0300, 8'h5a, 1'b0);
		idle();
		rdchk(13'h0300, 8'h5a);
		req(3'h4, 13'h0000, 8'h00, 1'b1);
		idle();
		rdchk(13'h0105, 8'hff);
		rdchk(13'h1555, 8'hff);
		$display("gap and clear test done");
	endtask : t_gap
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (n_compared > 0 && error_cnt == 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// main sequence after a 12 cycle reset
	initial begin
		repeat (12) @(negedge clk);
		rst = 0;
		t_page();
		t_prot();
		t_gap();
		final_report();
	end
endmodule : peepc_host_tb
